// *** hdl/pulse_output_auto_gate.sv ***
// pulse output auto-gate: gates the pwm waveform onto the pulse pin
`timescale 1ns/1ns

// Function
// - pin carries pwm only while output-valid bit is 1
// - auto-gate bit 1 selects gating by interval timer underflows
// - auto-gating turned off while closed keeps the output closed
// - auto-gating turned off while open keeps the output open
// - interval timer stopped forces auto-gating off
module pulse_output_auto_gate
  import pulse_gate_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire gate_ctrl_t ctrl,
  input  wire logic       pwm_in,
  input  wire logic       interval_run,
  input  wire logic       interval_underflow,
  output logic            pulse_output_pin,
  output logic            gate_open,
  output logic            auto_mode
);

  // ==========================================================
  // mode tracking
  gate_mode_t mode_q;
  gate_mode_t mode_d;
  logic       run_q;
  logic       gate_q;
  logic       gate_d;
  logic       pin_q;
  logic       auto_now;

  // auto gating needs both the select bit and a running timer
  assign auto_now = auto_active(ctrl, interval_run);

  // the enum tracks whether auto gating drives the gate this cycle
  always_comb begin
    case (auto_now)
      1'b1:    mode_d = GATE_AUTO;
      default: mode_d = GATE_MANUAL;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= GATE_MANUAL;
      run_q  <= 1'b0;
    end else begin
      mode_q <= mode_d;
      // run_q remembers the timer state to spot its start
      run_q  <= interval_run;
    end
  end

  // ==========================================================
  // gate state
  always_comb begin
    // with auto gating off the gate keeps whatever state it had
    gate_d = gate_q;
    if (auto_now && interval_underflow) begin
      gate_d = ~gate_q;
    end
    if (auto_now && interval_run && !run_q) begin
      // timer just started: next underflow must open
      gate_d = 1'b0;
      // a start that coincides with an underflow opens at once
      if (interval_underflow) begin
        gate_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= RST_GATE_OPEN;
    end else begin
      gate_q <= gate_d;
    end
  end

  // ==========================================================
  // pin drive
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= RST_PIN;
    end else begin
      // auto mode or held state both gate via gate_d
      // so the pin and gate_open switch on the same edge
      pin_q <= pwm_in & ctrl.output_valid & gate_d;
    end
  end

  // status outputs, registered like the pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_mode <= RST_AUTO_MODE;
      gate_open <= RST_GATE_OPEN;
    end else begin
      auto_mode <= (mode_d == GATE_AUTO);
      gate_open <= gate_d;
    end
  end

  assign pulse_output_pin = pin_q;

  // ==========================================================
  // checks: pin
  // all checks run on the rising edge and pause during reset
  pin_valid_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !$past(ctrl.output_valid) |-> !pulse_output_pin
  )
  else $error("pin active while output invalid");

  pin_follow_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ($past(ctrl.output_valid) && gate_open)
      |-> pulse_output_pin == $past(pwm_in)
  )
  else $error("pin does not follow pwm");

  gate_pin_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !gate_open |-> !pulse_output_pin
  )
  else $error("pin active while gate closed");

  // ==========================================================
  // checks: mode
  auto_sel_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl.auto_select && interval_run) |=> auto_mode
  )
  else $error("auto mode not selected");

  refuse_uf_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (interval_underflow && !ctrl.auto_select)
      |=> gate_open == $past(gate_q)
  )
  else $error("underflow moved gate without auto select");

  stop_off_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !interval_run |=> !auto_mode
  )
  else $error("auto mode survives timer stop");

  stop_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !interval_run |=> gate_open == $past(gate_q)
  )
  else $error("gate moved while timer stopped");

  // ==========================================================
  // checks: gate
  hold_closed_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!auto_now && !gate_q) |=> !gate_open
  )
  else $error("closed gate not held");

  hold_open_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!auto_now && gate_q) |=> gate_open
  )
  else $error("open gate not held");

  // mode_q marks the cycle after auto gating was on
  leave_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (mode_q == GATE_AUTO && !auto_now)
      |=> gate_open == $past(gate_q)
  )
  else $error("gate moved when auto gating ended");

  toggle_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (auto_now && run_q && interval_underflow)
      |=> gate_open != $past(gate_q)
  )
  else $error("underflow did not toggle gate");

  // a timer start resets the toggle phase
  start_open_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (auto_now && !run_q && interval_underflow) |=> gate_open
  )
  else $error("first underflow did not open");

  start_close_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (auto_now && !run_q && !interval_underflow) |=> !gate_open
  )
  else $error("timer start did not close gate");

  // ==========================================================
  // scenario covers
  // open, close, stop, start with underflow, leaving auto gating
  cover_open_c: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    auto_mode ##1 $rose(gate_open)
  );

  cover_close_c: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    auto_mode && $fell(gate_open)
  );

  cover_stop_c: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    gate_open ##1 $fell(auto_mode) ##1 gate_open
  );

  cover_start_c: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    auto_now && !run_q && interval_underflow
  );

  cover_leave_c: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    mode_q == GATE_AUTO && !auto_now && gate_q
  );

endmodule : pulse_output_auto_gate

// *** common/pulse_gate_pkg.sv ***
// package for the pulse output auto-gate block
package pulse_gate_pkg;

  // ==========================================================
  // reset values
  localparam logic RST_GATE_OPEN = 1'b0;
  localparam logic RST_PIN       = 1'b0;
  localparam logic RST_AUTO_MODE = 1'b0;

  // ==========================================================
  // control bits as one carrier
  typedef struct packed {
    logic output_valid;   // pulse_output_valid_bit
    logic auto_select;    // auto_gate_select_bit
  } gate_ctrl_t;

  // ==========================================================
  // gating state
  typedef enum logic [1:0] {
    GATE_MANUAL = 2'b00,
    GATE_AUTO   = 2'b01
  } gate_mode_t;

  // control word decode, used by logic and checks
  function automatic logic auto_active(input gate_ctrl_t c,
                                       input logic run);
    auto_active = c.auto_select & run;
  endfunction : auto_active

endpackage : pulse_gate_pkg

// *** bench/pin_load.sv ***
// load on the pulse pin, counts rising edges
`timescale 1ns/1ns
module pin_load (
  input  wire logic sys_clk,
  input  wire logic pulse_output_pin,
  output int        rises
);
  logic latch_q = 1'b0;
  logic prev_q  = 1'b0;
  initial rises = 0;
  always @(posedge sys_clk) begin
    prev_q <= pulse_output_pin | latch_q;
    if ((pulse_output_pin | latch_q) && !prev_q) rises <= rises + 1;
  end
endmodule : pin_load

// *** bench/pulse_output_auto_gate_test.sv ***
// self-checking bench for the pulse output auto-gate
`timescale 1ns/1ns
module pulse_output_auto_gate_test;
  import pulse_gate_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  gate_ctrl_t ctrl = '0;
  logic       pwm_in = 1'b0;
  logic       interval_run = 1'b0;
  logic       interval_underflow = 1'b0;
  logic       pulse_output_pin, gate_open, auto_mode;
  int         rises, failures = 0, checks_done = 0;
  always #4 sys_clk = ~sys_clk;
  pulse_output_auto_gate u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .ctrl(ctrl), .pwm_in(pwm_in), .interval_run(interval_run),
    .interval_underflow(interval_underflow),
    .pulse_output_pin(pulse_output_pin), .gate_open(gate_open),
    .auto_mode(auto_mode));
  pin_load u_load (.sys_clk(sys_clk),
    .pulse_output_pin(pulse_output_pin), .rises(rises));
  // ==========================================================
  // helpers
  task cyc;
    @(negedge sys_clk);
  endtask : cyc
  task chk(input logic e, input logic a, input string msg);
    checks_done++;
    if (a !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : chk
  task uf;
    interval_underflow = 1'b1;
    cyc;
    interval_underflow = 1'b0;
    cyc;
  endtask : uf
  task report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // scenarios
  task t_auto;
    ctrl = 2'b11;
    pwm_in = 1'b1;
    interval_run = 1'b1;
    repeat (2) cyc;
    chk(1'b1, auto_mode, "auto mode not on");
    chk(1'b0, gate_open, "gate open before underflow");
    chk(1'b0, pulse_output_pin, "pin active while closed");
    uf;
    chk(1'b1, gate_open, "first underflow did not open");
    cyc;
    chk(1'b1, pulse_output_pin, "pin not driven");
    pwm_in = 1'b0;
    cyc;
    chk(1'b0, pulse_output_pin, "pin ignores pwm low");
    pwm_in = 1'b1;
    cyc;
    chk(1'b1, pulse_output_pin, "pin ignores pwm high");
    ctrl.output_valid = 1'b0;
    repeat (2) cyc;
    chk(1'b0, pulse_output_pin, "pin active while invalid");
    chk(1'b1, rises == 2, "wrong pulse count at load");
    $display("auto test done");
  endtask : t_auto
  task t_hold;
    ctrl.auto_select = 1'b0;
    ctrl.output_valid = 1'b1;
    repeat (2) cyc;
    chk(1'b0, auto_mode, "auto mode stays on");
    chk(1'b1, pulse_output_pin, "open gate lost");
    uf;
    chk(1'b1, gate_open, "open gate not held");
    chk(1'b1, pulse_output_pin, "pin lost while held open");
    ctrl.auto_select = 1'b1;
    interval_run = 1'b0;
    uf;
    chk(1'b0, auto_mode, "auto mode survives stop");
    chk(1'b1, gate_open, "stop changed gate");
    $display("hold test done");
  endtask : t_hold
  task t_closed;
    interval_run = 1'b1;
    repeat (2) cyc;
    chk(1'b0, gate_open, "start did not close gate");
    chk(1'b0, pulse_output_pin, "pin active after start");
    uf;
    chk(1'b1, gate_open, "underflow did not open");
    uf;
    chk(1'b0, gate_open, "underflow did not close");
    ctrl.auto_select = 1'b0;
    uf;
    chk(1'b0, gate_open, "closed gate not held");
    chk(1'b0, pulse_output_pin, "pin active while held closed");
    $display("closed test done");
  endtask : t_closed
  task t_start;
    interval_run = 1'b0;
    ctrl.auto_select = 1'b1;
    cyc;
    interval_run = 1'b1;
    uf;
    chk(1'b1, gate_open, "start underflow did not open");
    chk(1'b1, auto_mode, "auto mode not on at start");
    chk(1'b1, pulse_output_pin, "pin not driven at start");
    $display("start test done");
  endtask : t_start
  task t_reset;
    rst_n = 1'b0;
    cyc;
    chk(1'b0, pulse_output_pin, "pin not cleared by reset");
    chk(1'b0, gate_open, "gate not closed by reset");
    chk(1'b0, auto_mode, "auto mode not cleared by reset");
    rst_n = 1'b1;
    cyc;
    chk(1'b1, auto_mode, "auto mode not back after reset");
    chk(1'b0, gate_open, "gate open after reset");
    uf;
    chk(1'b1, gate_open, "no open after reset");
    $display("reset test done");
  endtask : t_reset
  initial begin
    repeat (16) cyc;
    rst_n = 1'b1;
    cyc;
    t_auto;
    t_hold;
    t_closed;
    t_start;
    t_reset;
    report_and_stop;
  end
  initial begin
    #2000;
    failures++;
    report_and_stop;
  end
endmodule : pulse_output_auto_gate_test
